/* bench/jlc_link_config_assertions.sv */
/*
  Checker for the link configuration outputs of jlc_link_config.
  Assumes it is bound to that module and sees only its ports.
*/
`timescale 1ns/1ns
module jlc_link_checker #(
  parameter int LANES = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input jlc_pkg::jlc_link_cfg_s link_cfg,
  input wire logic link_rst_b,
  input wire logic link_clk_en,
  input wire logic align_seq_en,
  input wire logic [LANES-1:0] lane_power_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_clk_gate: assert property (link_clk_en == link_rst_b)
    else $error("clock gate and link reset disagree");
  a_pwr_off: assert property (!link_rst_b |-> lane_power_en == '0)
    else $error("lanes powered while link disabled");
  a_cfg_frozen: assert property (link_rst_b && $past(link_rst_b) |-> $stable(link_cfg))
    else $error("configuration changed while enabled");
  a_lanes_low: assert property (link_rst_b && $past(link_rst_b)
    |-> lane_power_en == LANES'((9'h1 << link_cfg.mode.l) - 9'h1))
    else $error("powered lanes do not match lane count");
  a_e_fixed: assert property (link_rst_b && link_cfg.mode.enc_64b
    |-> link_cfg.e_blocks == 8'h01)
    else $error("extended multiblock count not one");
  a_k_ignored: assert property (link_rst_b && link_cfg.mode.enc_64b
    |-> link_cfg.k_frames == '0)
    else $error("frame count used in 64b66b");
  a_align_8b: assert property (align_seq_en |-> !link_cfg.mode.enc_64b && link_rst_b)
    else $error("alignment sequence outside 8b10b");
  a_lane_count: assert property (link_rst_b
    |-> link_cfg.mode.l inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h8})
    else $error("lane count outside mode set");
endmodule : jlc_link_checker

bind jlc_link_config jlc_link_checker #(.LANES(LANES)) u_chk (.clk(clk), .rst_b(rst_b),
  .link_cfg(link_cfg), .link_rst_b(link_rst_b), .link_clk_en(link_clk_en),
  .align_seq_en(align_seq_en), .lane_power_en(lane_power_en));

/* bench/jlc_rx_model.sv */
/*
  Receiver side model: captures the unpack setup as the link starts.
  Assumes the configuration is stable while the link is out of reset.
*/
`timescale 1ns/1ns
module jlc_rx_model (
  input wire logic clk,
  input wire logic rst_b,
  input jlc_pkg::jlc_link_cfg_s link_cfg,
  input wire logic link_rst_b,
  output logic [3:0] unpack_m,
  output logic ilas_expected
);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      unpack_m <= 4'h0;
      ilas_expected <= 1'b0;
    end
    else if (link_rst_b)
    begin
      unpack_m <= link_cfg.mode.m;
      ilas_expected <= !link_cfg.mode.enc_64b;
    end
  end
endmodule : jlc_rx_model

/* bench/tb.sv */
/*
  Self-checking bench for jlc_link_config over every format code.
  Assumes a 20 MHz clock and an AXI4-Lite master that holds ready high.
*/
`timescale 1ns/1ns
module tb;
  logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, link_rst_b, link_clk_en, align_seq_en, rx_ilas;
  logic [7:0] awaddr, araddr, lane_power_en;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, rx_m;
  logic [1:0] bresp, rresp, bresp_seen;
  jlc_pkg::jlc_link_cfg_s link_cfg;
  int miscompares, checks, cycles;
  // Per code: R*32, 64b66b, L, M, F, S, N
  localparam bit [35:0] TBL [16] = '{36'h10008885c, 36'h14006422c, 36'h140044118,
    36'h190044a8a, 36'h21013421c, 36'h210124218, 36'h10816422c, 36'h108144118,
    36'h18c14432c, 36'h0a0084128, 36'h0c808854a, 36'h08008885c, 36'h050084148,
    36'h06408854a, 36'h0c618832c, 36'h06318832c};

  jlc_link_config #(.LANES(8)) i_dut (.clk(clk), .rst_b(rst_b),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .link_cfg(link_cfg), .link_rst_b(link_rst_b), .link_clk_en(link_clk_en),
    .align_seq_en(align_seq_en), .lane_power_en(lane_power_en));
  jlc_rx_model u_rx (.clk(clk), .rst_b(rst_b), .link_cfg(link_cfg),
    .link_rst_b(link_rst_b), .unpack_m(rx_m), .ilas_expected(rx_ilas));

  always #25 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    @(posedge clk);
    while (bvalid !== 1'b1) @(posedge clk);
    bresp_seen = bresp;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    arvalid <= 1'b1;
    araddr <= a;
    @(posedge clk);
    while (arready !== 1'b1) @(posedge clk);
    arvalid <= 1'b0;
    @(posedge clk);
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    r = rresp;
  endtask : bus_rd

  task automatic run_mode(input logic [3:0] m);
    bit [35:0] t;
    int enc, l, mm, f, s, n, stp, kmf, did, scr, ln, sum;
    int o[14];
    logic [31:0] d;
    logic [1:0] r;
    t = TBL[m];
    enc = t[23:20];
    l = t[19:16];
    mm = t[15:12];
    f = t[11:8];
    s = t[7:4];
    n = t[3:0];
    stp = (m == 0 || m == 11) ? 4 : (m == 1) ? 16 : 32;
    kmf = stp * $urandom_range(256 / stp, 1) - 1;
    did = $urandom_range(255, 0);
    scr = $urandom_range(1, 0);
    bus_wr(jlc_pkg::OFS_CTRL, 0);
    bus_wr(jlc_pkg::OFS_FORMAT, m);
    bus_wr(jlc_pkg::OFS_MULTIFRAME, kmf);
    bus_wr(jlc_pkg::OFS_DEVICE_ID, did);
    bus_wr(jlc_pkg::OFS_CTRL, scr * 2);
    bus_wr(jlc_pkg::OFS_CTRL, scr * 2 + 1);
    repeat (3) @(posedge clk);
    bus_rd(jlc_pkg::OFS_LINK_PARAMS, d, r);
    chk(d, {6'h0, enc == 0, enc[0], 4'(n), 4'(n), 4'(s), 4'(f), 4'(mm), 4'(l)});
    bus_rd(jlc_pkg::OFS_SERDES, d, r);
    chk(d, {8'h0, 8'((1 << l) - 1), 6'h0, 10'(t[35:24])});
    chk({link_cfg.k_frames, link_cfg.e_blocks}, {enc ? 9'h0 : 9'(kmf + 1), 8'(enc)});
    chk({link_cfg.device_id, link_cfg.scramble, link_clk_en}, {8'(did), scr[0], 1'b1});
    chk({rx_m, rx_ilas, align_seq_en}, {4'(mm), enc == 0, enc == 0});
    chk(link_cfg.mode, {enc[0], 4'(l), 4'(mm), 4'(f), 4'(s), 4'(n), 4'(n), t[33:24]});
    bus_wr(jlc_pkg::OFS_FORMAT, m + 1);
    chk(bresp_seen, jlc_pkg::RESP_OKAY);
    bus_rd(jlc_pkg::OFS_FORMAT, d, r);
    chk(d, m);
    if (enc == 0)
    begin
      ln = $urandom_range(l - 1, 0);
      o = '{did, 0, ln, scr * 128 + l - 1, f - 1, kmf, mm - 1, n - 1, 31 + n, 31 + s, 0, 0, 0, 0};
      sum = did + ln + scr + l + f + kmf + mm + n + n + s - 4;
      o[13] = sum % 256;
      for (int k = 0; k < 14; k++)
      begin
        bus_wr(jlc_pkg::OFS_ALIGN_SEL, k * 256 + ln);
        bus_rd(jlc_pkg::OFS_ALIGN_DATA, d, r);
        chk(d, o[k]);
      end
      bus_wr(jlc_pkg::OFS_ALIGN_SEL, 32'h0000_0e00);
      bus_rd(jlc_pkg::OFS_ALIGN_SEL, d, r);
      chk(d, 32'h0000_0d00);
    end
    bus_wr(jlc_pkg::OFS_CTRL, 0);
    repeat (2) @(posedge clk);
    chk({link_rst_b, link_clk_en, align_seq_en, lane_power_en}, 0);
  endtask : run_mode

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    clk = 1'b0;
    rst_b = 1'b0;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = 6'h3f;
    void'($urandom(86082));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus_rd(jlc_pkg::OFS_MULTIFRAME, d, r);
    chk({r, d}, 36'h1f);
    bus_rd(jlc_pkg::OFS_DEVICE_ID, d, r);
    chk({r, d}, 36'h0);
    bus_rd(8'h20, d, r);
    chk({r, d}, {jlc_pkg::RESP_SLVERR, 32'h0});
    bus_wr(8'h20, 32'h0000_0000);
    chk(bresp_seen, jlc_pkg::RESP_SLVERR);
    wstrb <= 4'h2;
    bus_wr(jlc_pkg::OFS_DEVICE_ID, 32'h0000_005a);
    wstrb <= 4'hf;
    bus_rd(jlc_pkg::OFS_DEVICE_ID, d, r);
    chk({r, d}, 36'h0);
    for (int m = 0; m < 16; m++)
      run_mode(m[3:0]);
    end_of_test();
  end
endmodule : tb

/* design/jlc_link_config.sv */
/*
  JESD204C transmit link parameter configuration with AXI4-Lite registers.
  Assumes one clock, a single-issue AXI4-Lite master and link logic that
  reads the configuration while the link enable is high.
*/
`timescale 1ns/1ns

// Behaviour
// - One written format code derives L, M, F, S, N, N', R and E; K, device identifier and scrambling are written separately.
// - Lane bit rate equals sampling clock times the derived factor R.
// - Factor R is the serializer PLL multiplication ratio.
// - K comes from the multiframe length field in 8B/10B only.
// - E is one in 64B/66B and ignored in 8B/10B.
// - Alignment parameter set is sent only in 8B/10B mode.
// - Adjust fields, bank, control words, high density, reserved read zero.
// - Control bits per sample is sent as zero.
// - Device identifier comes from a written register.
// - Each lane gets a derived identifier equal to its index.
// - L, F, N, N' and S derive from the selected mode.
// - Converter count M derives from the mode, receiver unpacks by M.
// - Checksum is the sum of preceding alignment fields modulo 256.
// - Parameters change only while disabled; disabled means reset, power down.
// - Lowest lanes are driven, higher unused lanes powered down.
module jlc_link_config #(
  parameter int LANES = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output jlc_pkg::jlc_link_cfg_s link_cfg,
  output logic link_rst_b,
  output logic link_clk_en,
  output logic align_seq_en,
  output logic [LANES-1:0] lane_power_en
);

  if (LANES != 8)
  begin : g_lanes_check
    $error("LANES must be 8 to serve the format table");
  end

  logic serial_link_enable;
  logic scramble;
  logic [3:0] link_format_select;
  logic [7:0] multiframe_length_minus_one;
  logic [7:0] device_id;
  logic [2:0] sel_lane;
  logic [3:0] sel_octet;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] next_rdata;
  logic next_rerr;

  localparam int SEL_OCTET_MSB = jlc_pkg::SEL_OCTET_LSB + 3;
  localparam logic [3:0] SUM_OCTET = jlc_pkg::ALIGN_OCTETS - 4'h1;

  jlc_pkg::jlc_mode_s mode_now;
  jlc_pkg::jlc_mode_s mode_q;

  // Writes land when both address and data are held
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire idle_link = !serial_link_enable;
  wire wr_ctrl = do_write && aw_addr == jlc_pkg::OFS_CTRL && w_strb[0];
  wire wr_format = do_write && aw_addr == jlc_pkg::OFS_FORMAT && w_strb[0];
  wire wr_mf = do_write && aw_addr == jlc_pkg::OFS_MULTIFRAME && w_strb[0];
  wire wr_id = do_write && aw_addr == jlc_pkg::OFS_DEVICE_ID && w_strb[0];
  wire wr_sel = do_write && aw_addr == jlc_pkg::OFS_ALIGN_SEL;
  wire wr_known = aw_addr == jlc_pkg::OFS_CTRL || aw_addr == jlc_pkg::OFS_FORMAT
    || aw_addr == jlc_pkg::OFS_MULTIFRAME || aw_addr == jlc_pkg::OFS_DEVICE_ID
    || aw_addr == jlc_pkg::OFS_ALIGN_SEL;
  wire [3:0] sel_octet_in = w_data[SEL_OCTET_MSB:jlc_pkg::SEL_OCTET_LSB];
  wire sel_octet_ok = sel_octet_in < jlc_pkg::ALIGN_OCTETS;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // Mode table decode
  assign mode_now = jlc_pkg::jlc_mode_lookup(link_format_select);

  // Alignment field values for one lane, minus-one coded where the link wants it
  function automatic logic [7:0] align_octet(
    input logic [3:0] idx,
    input logic [2:0] lane,
    input jlc_pkg::jlc_mode_s p,
    input logic [7:0] did,
    input logic [7:0] kmf,
    input logic scr
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      4'h0: v = did;
      4'h2: v = {3'b000, 2'b00, lane};
      4'h3: v = {scr, 3'b000, p.l - 4'h1};
      4'h4: v = {4'h0, p.f - 4'h1};
      4'h5: v = kmf;
      4'h6: v = {4'h0, p.m - 4'h1};
      4'h7: v = {4'h0, p.n - 4'h1};
      4'h8: v = {jlc_pkg::SUBCLASS_VERSION, 1'b0, p.n_tail - 4'h1};
      4'h9: v = {jlc_pkg::STANDARD_VERSION, 1'b0, p.s - 4'h1};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : align_octet

  // Checksum over field values, not over packed octets
  function automatic logic [7:0] align_sum(
    input logic [2:0] lane,
    input jlc_pkg::jlc_mode_s p,
    input logic [7:0] did,
    input logic [7:0] kmf,
    input logic scr
  );
    logic [7:0] sum;
    sum = did + {5'h00, lane} + {7'h00, scr};
    sum = sum + {4'h0, p.l - 4'h1} + {4'h0, p.f - 4'h1} + kmf;
    sum = sum + {4'h0, p.m - 4'h1} + {4'h0, p.n - 4'h1};
    sum = sum + {4'h0, p.n_tail - 4'h1} + {4'h0, p.s - 4'h1};
    sum = sum + {5'h00, jlc_pkg::SUBCLASS_VERSION};
    sum = sum + {5'h00, jlc_pkg::STANDARD_VERSION};
    return sum;
  endfunction : align_sum

  wire [7:0] sel_value = (sel_octet == SUM_OCTET)
    ? align_sum(sel_lane, mode_q, device_id, multiframe_length_minus_one, scramble)
    : align_octet(sel_octet, sel_lane, mode_q, device_id,
        multiframe_length_minus_one, scramble);

  // Lanes below L are powered
  function automatic logic [LANES-1:0] lane_mask(input logic [3:0] l);
    logic [LANES-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++)
      m[i] = 4'(i) < l;
    return m;
  endfunction : lane_mask

  // Read mux
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    unique case (s_axi_araddr)
      jlc_pkg::OFS_CTRL:
        next_rdata = {30'h0, scramble, serial_link_enable};
      jlc_pkg::OFS_FORMAT:
        next_rdata = {28'h0, link_format_select};
      jlc_pkg::OFS_MULTIFRAME:
        next_rdata = {24'h0, multiframe_length_minus_one};
      jlc_pkg::OFS_DEVICE_ID:
        next_rdata = {24'h0, device_id};
      jlc_pkg::OFS_LINK_PARAMS:
        next_rdata = {6'h0, align_seq_en, mode_q.enc_64b, mode_q.n_tail, mode_q.n,
          mode_q.s, mode_q.f, mode_q.m, mode_q.l};
      jlc_pkg::OFS_SERDES:
        next_rdata = {8'h0, lane_power_en, 6'h0, mode_q.r_x32};
      jlc_pkg::OFS_ALIGN_SEL:
        next_rdata = {20'h0, sel_octet, 5'h0, sel_lane};
      jlc_pkg::OFS_ALIGN_DATA:
        next_rdata = {24'h0, sel_value};
      default:
        next_rerr = 1'b1;
    endcase
  end

  // Write channel capture, either order
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= jlc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? jlc_pkg::RESP_OKAY : jlc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read response
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= jlc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? jlc_pkg::RESP_SLVERR : jlc_pkg::RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Control and link parameter registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      serial_link_enable <= 1'b0;
      scramble <= 1'b0;
      link_format_select <= jlc_pkg::FORMAT_RESET;
      multiframe_length_minus_one <= jlc_pkg::MULTIFRAME_RESET;
      device_id <= jlc_pkg::DEVICE_ID_RESET;
      sel_lane <= 3'h0;
      sel_octet <= 4'h0;
    end
    else
    begin
      if (wr_ctrl)
        serial_link_enable <= w_data[jlc_pkg::CTRL_ENABLE_BIT];
      if (wr_ctrl && idle_link)
        scramble <= w_data[jlc_pkg::CTRL_SCRAMBLE_BIT];
      if (wr_format && idle_link)
        link_format_select <= w_data[3:0];
      if (wr_mf && idle_link)
        multiframe_length_minus_one <= w_data[7:0];
      if (wr_id && idle_link)
        device_id <= w_data[7:0];
      if (wr_sel && w_strb[0])
        sel_lane <= w_data[2:0];
      if (wr_sel && w_strb[1] && sel_octet_ok)
        sel_octet <= sel_octet_in;
    end
  end

  // Registered link outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_q <= '0;
      link_cfg <= '0;
      link_rst_b <= 1'b0;
      link_clk_en <= 1'b0;
      align_seq_en <= 1'b0;
      lane_power_en <= '0;
    end
    else
    begin
      mode_q <= mode_now;
      link_cfg.mode <= mode_q;
      link_cfg.k_frames <= mode_q.enc_64b ? 9'h000
        : {1'b0, multiframe_length_minus_one} + 9'h001;
      link_cfg.e_blocks <= mode_q.enc_64b ? jlc_pkg::EXT_MULTIBLOCK : 8'h00;
      link_cfg.device_id <= device_id;
      link_cfg.scramble <= scramble;
      link_rst_b <= serial_link_enable;
      link_clk_en <= serial_link_enable;
      align_seq_en <= serial_link_enable && !mode_q.enc_64b;
      lane_power_en <= serial_link_enable ? lane_mask(mode_q.l) : '0;
    end
  end

endmodule : jlc_link_config

/* design/jlc_pkg.sv */
/*
  Shared constants, types and the link format table for the JESD204C
  link parameter configuration block.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package jlc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FORMAT = 8'h04;
  localparam logic [7:0] OFS_MULTIFRAME = 8'h08;
  localparam logic [7:0] OFS_DEVICE_ID = 8'h0c;
  localparam logic [7:0] OFS_LINK_PARAMS = 8'h10;
  localparam logic [7:0] OFS_SERDES = 8'h14;
  localparam logic [7:0] OFS_ALIGN_SEL = 8'h18;
  localparam logic [7:0] OFS_ALIGN_DATA = 8'h1c;

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SCRAMBLE_BIT = 1;
  localparam int SEL_OCTET_LSB = 8;

  // Reset values
  localparam logic [3:0] FORMAT_RESET = 4'h0;
  localparam logic [7:0] MULTIFRAME_RESET = 8'h1f;
  localparam logic [7:0] DEVICE_ID_RESET = 8'h00;

  // Fixed alignment field values, E value, alignment octet count and bus response codes
  localparam logic [2:0] SUBCLASS_VERSION = 3'h1;
  localparam logic [2:0] STANDARD_VERSION = 3'h1;
  localparam logic [7:0] EXT_MULTIBLOCK = 8'h01;
  localparam logic [3:0] ALIGN_OCTETS = 4'he;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Per-mode derived parameters; r_x32 is R times 32
  typedef struct packed {
    logic enc_64b;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic [3:0] n;
    logic [3:0] n_tail;
    logic [9:0] r_x32;
  } jlc_mode_s;

  function automatic jlc_mode_s jlc_mode_lookup(input logic [3:0] sel);
    jlc_mode_s p;
    unique case (sel)
      4'h0: p = '{1'b0, 4'h8, 4'h8, 4'h8, 4'h5, 4'hc, 4'hc, 10'h100};
      4'h1: p = '{1'b0, 4'h6, 4'h4, 4'h2, 4'h2, 4'hc, 4'hc, 10'h140};
      4'h2: p = '{1'b0, 4'h4, 4'h4, 4'h1, 4'h1, 4'h8, 4'h8, 10'h140};
      4'h3: p = '{1'b0, 4'h4, 4'h4, 4'ha, 4'h8, 4'ha, 4'ha, 10'h190};
      4'h4: p = '{1'b1, 4'h3, 4'h4, 4'h2, 4'h1, 4'hc, 4'hc, 10'h210};
      4'h5: p = '{1'b1, 4'h2, 4'h4, 4'h2, 4'h1, 4'h8, 4'h8, 10'h210};
      4'h6: p = '{1'b1, 4'h6, 4'h4, 4'h2, 4'h2, 4'hc, 4'hc, 10'h108};
      4'h7: p = '{1'b1, 4'h4, 4'h4, 4'h1, 4'h1, 4'h8, 4'h8, 10'h108};
      4'h8: p = '{1'b1, 4'h4, 4'h4, 4'h3, 4'h2, 4'hc, 4'hc, 10'h18c};
      4'h9: p = '{1'b0, 4'h8, 4'h4, 4'h1, 4'h2, 4'h8, 4'h8, 10'h0a0};
      4'ha: p = '{1'b0, 4'h8, 4'h8, 4'h5, 4'h4, 4'ha, 4'ha, 10'h0c8};
      4'hb: p = '{1'b0, 4'h8, 4'h8, 4'h8, 4'h5, 4'hc, 4'hc, 10'h080};
      4'hc: p = '{1'b0, 4'h8, 4'h4, 4'h1, 4'h4, 4'h8, 4'h8, 10'h050};
      4'hd: p = '{1'b0, 4'h8, 4'h8, 4'h5, 4'h4, 4'ha, 4'ha, 10'h064};
      4'he: p = '{1'b1, 4'h8, 4'h8, 4'h3, 4'h2, 4'hc, 4'hc, 10'h0c6};
      4'hf: p = '{1'b1, 4'h8, 4'h8, 4'h3, 4'h2, 4'hc, 4'hc, 10'h063};
    endcase
    return p;
  endfunction : jlc_mode_lookup

  // Link outputs toward the framer and serializers
  typedef struct packed {
    jlc_mode_s mode;
    logic [8:0] k_frames;
    logic [7:0] e_blocks;
    logic [7:0] device_id;
    logic scramble;
  } jlc_link_cfg_s;

endpackage : jlc_pkg
